//--- dv/clcb_monitor.sv
// Purpose: Concurrent checks on the closed-loop settings bank ports
// Assumes: One clock, asynchronous active-low reset
// Notes:   Decoded outputs lag a register write by one clock
module clcb_monitor (
    input logic        i_ref_clk,
    input logic        i_rst_n,
    input logic        i_psel,
    input logic        i_penable,
    input logic        i_pwrite,
    input logic [11:0] i_paddr,
    input logic [31:0] i_pwdata,
    input logic [3:0]  i_pstrb,
    input logic        o_pslverr,
    input logic        o_fast_sampling_select,
    input logic [3:0]  o_max_sample_khz,
    input logic        o_stop_hiz,
    input logic        o_stop_spin_down,
    input logic        o_stop_brake,
    input logic        o_overmod_en,
    input logic [17:0] o_accel_rate,
    input logic        o_accel_unlimited,
    input logic        o_decel_source_select,
    input logic        o_decel_valid,
    input logic [17:0] o_decel_rate,
    input logic        o_decel_unlimited
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire acc_phase = i_psel && i_penable;
    wire mapped    = (i_paddr == 12'h040) || (i_paddr == 12'h044);
    wire cl_write  = acc_phase && i_pwrite && (i_paddr == 12'h044);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_slverr_unmapped: assert property (acc_phase && !mapped |-> o_pslverr)
        else $error("no slave error on unmapped access");
    a_slverr_mapped: assert property (acc_phase && mapped |-> !o_pslverr)
        else $error("slave error on mapped access");
    a_rate_cap: assert property (o_max_sample_khz == (o_fast_sampling_select ? 4'h5 : 4'ha))
        else $error("sampling cap does not match select");
    a_fast_follows: assert property (cl_write && i_pstrb[3] |-> ##2 o_fast_sampling_select == $past(i_pwdata[27], 2))
        else $error("sampling select not taken from write");
    a_overmod_follows: assert property (cl_write && i_pstrb[2] |-> ##2 o_overmod_en == $past(i_pwdata[19], 2))
        else $error("overmodulation not taken from write");
    a_stop_onehot: assert property ($onehot({o_stop_hiz, o_stop_spin_down, o_stop_brake}))
        else $error("stop method not one-hot");
    a_stop_resv_hold: assert property (cl_write && i_pstrb[2] && i_pwdata[21:20] == 2'h3 |-> ##2 $stable({o_stop_hiz, o_stop_spin_down, o_stop_brake}))
        else $error("reserved stop code changed stop method");
    a_unl_zero: assert property (o_accel_unlimited |-> o_accel_rate == 18'h0)
        else $error("unlimited accel with nonzero rate");
    a_decel_shared: assert property (o_decel_source_select |-> o_decel_valid && o_decel_rate == o_accel_rate && o_decel_unlimited == o_accel_unlimited)
        else $error("decel does not follow accel");
endmodule

bind clcb_config_bank clcb_monitor u_mon (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pslverr(o_pslverr),
    .o_fast_sampling_select(o_fast_sampling_select), .o_max_sample_khz(o_max_sample_khz),
    .o_stop_hiz(o_stop_hiz), .o_stop_spin_down(o_stop_spin_down), .o_stop_brake(o_stop_brake),
    .o_overmod_en(o_overmod_en), .o_accel_rate(o_accel_rate), .o_accel_unlimited(o_accel_unlimited),
    .o_decel_source_select(o_decel_source_select), .o_decel_valid(o_decel_valid),
    .o_decel_rate(o_decel_rate), .o_decel_unlimited(o_decel_unlimited)
);

//--- dv/clcb_testbench.sv
// Purpose: Register and decode tests for the closed-loop settings bank
// Assumes: Decoded outputs settle one clock after a write
// Notes:   Units 0.01 deg/ms, 0.1 percent, 0.5 Hz/s
`include "clcb_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rb;
    logic [3:0]  i_pstrb = 4'h0;
    logic        er;
    logic [4:0]  c;
    wire  [31:0] o_prdata;
    wire  [17:0] o_accel_rate, o_decel_rate;
    wire  [9:0]  o_current_limit;
    wire  [7:0]  o_theta_ramp_rate;
    wire  [3:0]  o_max_sample_khz;
    wire o_pready, o_pslverr, o_fast_sampling_select, o_stop_hiz, o_stop_spin_down, o_stop_brake, o_overmod_en;
    wire o_accel_unlimited, o_decel_source_select, o_decel_valid, o_decel_unlimited;
    int fails = 0, checked = 0;
    logic [7:0] th_t [8] = '{8'h01, 8'h05, 8'h0a, 8'h0f, 8'h14, 8'h32, 8'h64, 8'hc8};
    logic [9:0] il_t [32] = '{10'h04b, 10'h050, 10'h055, 10'h05a, 10'h05f, 10'h064, 10'h06e, 10'h078,
        10'h082, 10'h08c, 10'h096, 10'h0a0, 10'h0aa, 10'h0b4, 10'h0c8, 10'h0e1, 10'h0fa, 10'h113, 10'h12c,
        10'h15e, 10'h190, 10'h1c2, 10'h1f4, 10'h226, 10'h258, 10'h2bc, 10'h2ee, 10'h320, 10'h352, 10'h384,
        10'h3b6, 10'h3e8};
    logic [17:0] rt_t [32] = '{18'h1, 18'h2, 18'h5, 18'ha, 18'hf, 18'h14, 18'h28, 18'h50, 18'h78, 18'ha0,
        18'hc8, 18'h190, 18'h258, 18'h320, 18'h3e8, 18'h4b0, 18'h578, 18'h640, 18'h708, 18'h7d0, 18'hfa0,
        18'h1f40, 18'h2ee0, 18'h3e80, 18'h4e20, 18'h9c40, 18'hea60, 18'h13880, 18'h186a0, 18'h1d4c0,
        18'h222e0, 18'h0};
    logic [1:0] sc [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3};
    logic [2:0] se [5] = '{3'h2, 3'h2, 3'h1, 3'h4, 3'h4};

    clcb_config_bank DUT (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_theta_ramp_rate(o_theta_ramp_rate), .o_max_sample_khz(o_max_sample_khz),
        .o_fast_sampling_select(o_fast_sampling_select), .o_current_limit(o_current_limit),
        .o_stop_hiz(o_stop_hiz), .o_stop_spin_down(o_stop_spin_down), .o_stop_brake(o_stop_brake),
        .o_overmod_en(o_overmod_en), .o_accel_rate(o_accel_rate), .o_accel_unlimited(o_accel_unlimited),
        .o_decel_source_select(o_decel_source_select), .o_decel_valid(o_decel_valid),
        .o_decel_rate(o_decel_rate), .o_decel_unlimited(o_decel_unlimited)
    );

    always #5 i_ref_clk = ~i_ref_clk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One transfer; the request holds until pready is sampled high, giving up after 20 clocks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        i_pstrb <= s;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rb = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (o_pready !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        chk({o_theta_ramp_rate, o_max_sample_khz, o_stop_hiz, o_stop_spin_down, o_overmod_en, o_decel_valid},
            {8'h01, 4'ha, 4'h9});
        chk({o_current_limit, o_accel_rate, o_decel_rate}, {10'h04b, 18'h1, 18'h1});
        apb(1'b0, `CLCB_CL1_OFF, 32'h0, 4'h0);
        chk({er, rb}, {1'b0, `CLCB_CL1_RST});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(`CLCB_SU2_OFF, i);
            chk(o_theta_ramp_rate, th_t[i]);
        end
        $display("test theta done");
        for (int i = 0; i < 32; i++) begin
            c = i[4:0];
            wr(`CLCB_CL1_OFF, {4'h0, c[0], c, 3'h0, c, 1'b1, 13'h0});
            chk(rb, {4'h0, c[0], c, 3'h0, c, 1'b1, 13'h0});
            chk(o_current_limit, il_t[c]);
            chk({o_fast_sampling_select, o_max_sample_khz}, {c[0], c[0] ? 4'h5 : 4'ha});
            chk({o_decel_source_select, o_decel_unlimited, o_decel_rate}, {1'b1, c == 5'h1f, rt_t[c]});
            chk({o_accel_unlimited, o_accel_rate}, {c == 5'h1f, rt_t[c]});
            wr(`CLCB_CL1_OFF, {13'h0, ~c, 1'b0, c, 4'h0, c[0], 3'h0});
            chk({o_decel_source_select, o_decel_unlimited, o_decel_rate}, {1'b0, c == 5'h1f, rt_t[c]});
            chk({o_decel_valid, o_accel_rate}, {~c[0], rt_t[~c]});
        end
        $display("test rates done");
        for (int k = 0; k < 5; k++) begin
            wr(`CLCB_CL1_OFF, {4'ha, 6'h0, sc[k], k[0], 19'h0});
            chk({o_stop_hiz, o_stop_spin_down, o_stop_brake}, se[k]);
            chk(o_overmod_en, k[0]);
            chk({rb, o_max_sample_khz, o_current_limit}, {4'ha, 6'h0, sc[k], k[0], 19'h0, 4'ha, 10'h04b});
        end
        $display("test stop done");
        apb(1'b1, `CLCB_CL1_OFF, 32'hffffffff, 4'h2);
        apb(1'b0, `CLCB_CL1_OFF, 32'h0, 4'h0);
        chk(rb, 32'ha030ff00);
        apb(1'b1, 12'h048, 32'h12345678, 4'hf);
        chk(er, 1'b1);
        apb(1'b0, 12'h048, 32'h0, 4'h0);
        chk({er, rb}, {1'b1, 32'h0});
        apb(1'b0, `CLCB_CL1_OFF, 32'h0, 4'h0);
        chk({er, rb}, {1'b0, 32'ha030ff00});
        $display("test strobe and unmapped done");
        end_sim();
    end
endmodule

//--- hw/clcb_config_bank.v
// Purpose: APB register bank for closed-loop motor settings, with decoded operating values
// Assumes: APB master on i_ref_clk; all fields stored as written
// Notes:   Decoded outputs follow a register write by one clock
`include "clcb_defs.vh"

module clcb_config_bank (
    input  wire                    i_ref_clk,
    input  wire                    i_rst_n,
    input  wire                    i_psel,
    input  wire                    i_penable,
    input  wire                    i_pwrite,
    input  wire [`CLCB_ADDR_W-1:0] i_paddr,
    input  wire [`CLCB_DATA_W-1:0] i_pwdata,
    input  wire [`CLCB_STRB_W-1:0] i_pstrb,
    output wire [`CLCB_DATA_W-1:0] o_prdata,
    output wire                    o_pready,
    output wire                    o_pslverr,
    output wire [7:0]              o_theta_ramp_rate,
    output wire                    o_fast_sampling_select,
    output wire [3:0]              o_max_sample_khz,
    output wire [9:0]              o_current_limit,
    output wire                    o_stop_hiz,
    output wire                    o_stop_spin_down,
    output wire                    o_stop_brake,
    output wire                    o_overmod_en,
    output wire [17:0]             o_accel_rate,
    output wire                    o_accel_unlimited,
    output wire                    o_decel_source_select,
    output wire                    o_decel_valid,
    output wire [17:0]             o_decel_rate,
    output wire                    o_decel_unlimited
);

    // ----------------------------------------
    // Storage and output registers
    // ----------------------------------------
    reg  [31:0] su2_reg;
    reg  [31:0] su2_next;
    reg  [31:0] cl1_reg;
    reg  [31:0] cl1_next;
    reg  [31:0] prdata_reg;
    reg  [31:0] prdata_next;
    reg  [7:0]  theta_reg;
    reg         fast_reg;
    reg  [3:0]  khz_reg;
    reg  [9:0]  ilim_reg;
    reg  [1:0]  stop_reg;
    reg  [1:0]  stop_next;
    reg         ovm_reg;
    reg  [17:0] acc_reg;
    reg         acc_unl_reg;
    reg         dsrc_reg;
    reg         dvalid_reg;
    reg  [17:0] dec_reg;
    reg         dec_unl_reg;
    reg  [17:0] dec_next;
    reg         dec_unl_next;

    wire        setup_phase;
    wire        access_phase;
    wire        hit_su2;
    wire        hit_cl1;
    wire        mapped;
    wire        wr_en;
    wire [17:0] acc_rate;
    wire        acc_unl;
    wire [17:0] decf_rate;
    wire        decf_unl;
    wire [1:0]  stop_field;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Merge write data into a word under byte enables
    function [31:0] merge_bytes;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0]  strb;
        integer      i;
        begin
            merge_bytes = old_word;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[i*8 +: 8] = new_word[i*8 +: 8];
                end
            end
        end
    endfunction

    // Theta ramp in steps of 0.01 deg/ms
    function [7:0] theta_decode;
        input [2:0] code;
        begin
            case (code)
                3'h0:    theta_decode = 8'h01;
                3'h1:    theta_decode = 8'h05;
                3'h2:    theta_decode = 8'h0a;
                3'h3:    theta_decode = 8'h0f;
                3'h4:    theta_decode = 8'h14;
                3'h5:    theta_decode = 8'h32;
                3'h6:    theta_decode = 8'h64;
                default: theta_decode = 8'hc8;
            endcase
        end
    endfunction

    // Current limit in steps of 0.1% of base current
    function [9:0] ilim_decode;
        input [4:0] code;
        begin
            case (code)
                5'h00:   ilim_decode = 10'h04b;
                5'h01:   ilim_decode = 10'h050;
                5'h02:   ilim_decode = 10'h055;
                5'h03:   ilim_decode = 10'h05a;
                5'h04:   ilim_decode = 10'h05f;
                5'h05:   ilim_decode = 10'h064;
                5'h06:   ilim_decode = 10'h06e;
                5'h07:   ilim_decode = 10'h078;
                5'h08:   ilim_decode = 10'h082;
                5'h09:   ilim_decode = 10'h08c;
                5'h0a:   ilim_decode = 10'h096;
                5'h0b:   ilim_decode = 10'h0a0;
                5'h0c:   ilim_decode = 10'h0aa;
                5'h0d:   ilim_decode = 10'h0b4;
                5'h0e:   ilim_decode = 10'h0c8;
                5'h0f:   ilim_decode = 10'h0e1;
                5'h10:   ilim_decode = 10'h0fa;
                5'h11:   ilim_decode = 10'h113;
                5'h12:   ilim_decode = 10'h12c;
                5'h13:   ilim_decode = 10'h15e;
                5'h14:   ilim_decode = 10'h190;
                5'h15:   ilim_decode = 10'h1c2;
                5'h16:   ilim_decode = 10'h1f4;
                5'h17:   ilim_decode = 10'h226;
                5'h18:   ilim_decode = 10'h258;
                5'h19:   ilim_decode = 10'h2bc;
                5'h1a:   ilim_decode = 10'h2ee;
                5'h1b:   ilim_decode = 10'h320;
                5'h1c:   ilim_decode = 10'h352;
                5'h1d:   ilim_decode = 10'h384;
                5'h1e:   ilim_decode = 10'h3b6;
                default: ilim_decode = 10'h3e8;
            endcase
        end
    endfunction

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Zero wait states: every access phase completes on its first edge
    // Unmapped offsets answer with an error, drop writes and read as zero
    assign setup_phase  = i_psel & ~i_penable;
    assign access_phase = i_psel & i_penable;
    assign hit_su2      = (i_paddr == `CLCB_SU2_OFF);
    assign hit_cl1      = (i_paddr == `CLCB_CL1_OFF);
    assign mapped       = hit_su2 | hit_cl1;
    assign wr_en        = access_phase & i_pwrite;
    assign o_pready     = 1'b1;
    assign o_pslverr    = access_phase & ~mapped;
    assign o_prdata     = prdata_reg;

    always @* begin
        su2_next = su2_reg;
        cl1_next = cl1_reg;
        if (wr_en && hit_su2) begin
            su2_next = merge_bytes(su2_reg, i_pwdata, i_pstrb);
        end
        if (wr_en && hit_cl1) begin
            // All bits stored, reserved ones included
            cl1_next = merge_bytes(cl1_reg, i_pwdata, i_pstrb);
        end
    end

    // Read data is latched in the setup cycle so it comes from a flop
    always @* begin
        prdata_next = prdata_reg;
        if (setup_phase && !i_pwrite) begin
            if (hit_su2) begin
                prdata_next = su2_reg;
            end else if (hit_cl1) begin
                prdata_next = cl1_reg;
            end else begin
                prdata_next = 32'h00000000;
            end
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            su2_reg    <= `CLCB_SU2_RST;
            cl1_reg    <= `CLCB_CL1_RST;
            prdata_reg <= 32'h00000000;
        end else begin
            su2_reg    <= su2_next;
            cl1_reg    <= cl1_next;
            prdata_reg <= prdata_next;
        end
    end

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    clcb_rate_decode u_acc_decode (
        .i_code      (cl1_reg[`CLCB_ACC_MSB:`CLCB_ACC_LSB]),
        .o_rate      (acc_rate),
        .o_unlimited (acc_unl)
    );

    clcb_rate_decode u_dec_decode (
        .i_code      (cl1_reg[`CLCB_DEC_MSB:`CLCB_DEC_LSB]),
        .o_rate      (decf_rate),
        .o_unlimited (decf_unl)
    );

    assign stop_field = cl1_reg[`CLCB_STOP_MSB:`CLCB_STOP_LSB];

    // Reserved stop code keeps the last valid method in force
    always @* begin
        case (stop_field)
            `CLCB_STOP_HIZ:   stop_next = `CLCB_STOP_HIZ;
            `CLCB_STOP_SPIN:  stop_next = `CLCB_STOP_SPIN;
            `CLCB_STOP_BRAKE: stop_next = `CLCB_STOP_BRAKE;
            default:          stop_next = stop_reg;
        endcase
    end

    // Deceleration source; with scaling on and bit 13 low no table rate applies
    always @* begin
        if (cl1_reg[`CLCB_DSRC_BIT]) begin
            dec_next     = acc_rate;
            dec_unl_next = acc_unl;
        end else begin
            dec_next     = decf_rate;
            dec_unl_next = decf_unl;
        end
    end

    // ----------------------------------------
    // Decoded outputs
    // ----------------------------------------
    // Outputs come from flops, but the three stop flags are compares on stop_reg, so only they can show decode glitches;
    // the price is one clock of lag after every register write
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            theta_reg   <= 8'h01;
            fast_reg    <= 1'b0;
            khz_reg     <= `CLCB_FAST_KHZ;
            ilim_reg    <= 10'h04b;
            stop_reg    <= `CLCB_STOP_HIZ;
            ovm_reg     <= 1'b0;
            acc_reg     <= 18'h00001;
            acc_unl_reg <= 1'b0;
            dsrc_reg    <= 1'b0;
            dvalid_reg  <= 1'b1;
            dec_reg     <= 18'h00001;
            dec_unl_reg <= 1'b0;
        end else begin
            theta_reg   <= theta_decode(su2_reg[`CLCB_THETA_MSB:`CLCB_THETA_LSB]);
            fast_reg    <= cl1_reg[`CLCB_FAST_BIT];
            khz_reg     <= cl1_reg[`CLCB_FAST_BIT] ? `CLCB_SLOW_KHZ : `CLCB_FAST_KHZ;
            ilim_reg    <= ilim_decode(cl1_reg[`CLCB_ILIM_MSB:`CLCB_ILIM_LSB]);
            stop_reg    <= stop_next;
            ovm_reg     <= cl1_reg[`CLCB_OVM_BIT];
            acc_reg     <= acc_rate;
            acc_unl_reg <= acc_unl;
            dsrc_reg    <= cl1_reg[`CLCB_DSRC_BIT];
            dvalid_reg  <= cl1_reg[`CLCB_DSRC_BIT] | ~cl1_reg[`CLCB_AVS_BIT];
            dec_reg     <= dec_next;
            dec_unl_reg <= dec_unl_next;
        end
    end

    assign o_theta_ramp_rate      = theta_reg;
    assign o_fast_sampling_select = fast_reg;
    assign o_max_sample_khz       = khz_reg;
    assign o_current_limit        = ilim_reg;
    assign o_stop_hiz             = (stop_reg == `CLCB_STOP_HIZ);
    assign o_stop_spin_down       = (stop_reg == `CLCB_STOP_SPIN);
    assign o_stop_brake           = (stop_reg == `CLCB_STOP_BRAKE);
    assign o_overmod_en           = ovm_reg;
    assign o_accel_rate           = acc_reg;
    assign o_accel_unlimited      = acc_unl_reg;
    assign o_decel_source_select  = dsrc_reg;
    assign o_decel_valid          = dvalid_reg;
    assign o_decel_rate           = dec_reg;
    assign o_decel_unlimited      = dec_unl_reg;

endmodule

//--- hw/clcb_defs.vh
// Purpose: Offsets, field positions, reset values and rates of the closed-loop settings bank
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef CLCB_DEFS_VH
`define CLCB_DEFS_VH

// ----------------------------------------
// Bus and register map
// ----------------------------------------
`define CLCB_ADDR_W          12
`define CLCB_DATA_W          32
`define CLCB_STRB_W          4
`define CLCB_SU2_OFF         12'h040
`define CLCB_CL1_OFF         12'h044
`define CLCB_SU2_RST         32'h00000000
`define CLCB_CL1_RST         32'h00000000

// ----------------------------------------
// Startup register fields
// ----------------------------------------
`define CLCB_THETA_MSB       2
`define CLCB_THETA_LSB       0

// ----------------------------------------
// Closed-loop register fields
// ----------------------------------------
`define CLCB_RSVD_MSB        31
`define CLCB_RSVD_LSB        28
`define CLCB_FAST_BIT        27
`define CLCB_ILIM_MSB        26
`define CLCB_ILIM_LSB        22
`define CLCB_STOP_MSB        21
`define CLCB_STOP_LSB        20
`define CLCB_OVM_BIT         19
`define CLCB_ACC_MSB         18
`define CLCB_ACC_LSB         14
`define CLCB_DSRC_BIT        13
`define CLCB_DEC_MSB         12
`define CLCB_DEC_LSB         8
`define CLCB_AVS_BIT         3

// ----------------------------------------
// Stop method codes
// ----------------------------------------
`define CLCB_STOP_HIZ        2'h0
`define CLCB_STOP_SPIN       2'h1
`define CLCB_STOP_BRAKE      2'h2
`define CLCB_STOP_RSVD       2'h3

// ----------------------------------------
// Sampling rate caps in kHz
// ----------------------------------------
`define CLCB_FAST_KHZ        4'ha
`define CLCB_SLOW_KHZ        4'h5

`endif

//--- hw/clcb_rate_decode.v
// Purpose: Map a 5-bit ramp rate code to a rate in steps of 0.5 Hz/s
// Assumes: Code 1f means no limit
// Notes:   Shared by the acceleration and deceleration fields
module clcb_rate_decode (
    input  wire [4:0]  i_code,
    output reg  [17:0] o_rate,
    output reg         o_unlimited
);

    // ----------------------------------------
    // Rate table
    // ----------------------------------------
    always @* begin
        o_unlimited = 1'b0;
        case (i_code)
            5'h00: o_rate = 18'h00001;
            5'h01: o_rate = 18'h00002;
            5'h02: o_rate = 18'h00005;
            5'h03: o_rate = 18'h0000a;
            5'h04: o_rate = 18'h0000f;
            5'h05: o_rate = 18'h00014;
            5'h06: o_rate = 18'h00028;
            5'h07: o_rate = 18'h00050;
            5'h08: o_rate = 18'h00078;
            5'h09: o_rate = 18'h000a0;
            5'h0a: o_rate = 18'h000c8;
            5'h0b: o_rate = 18'h00190;
            5'h0c: o_rate = 18'h00258;
            5'h0d: o_rate = 18'h00320;
            5'h0e: o_rate = 18'h003e8;
            5'h0f: o_rate = 18'h004b0;
            5'h10: o_rate = 18'h00578;
            5'h11: o_rate = 18'h00640;
            5'h12: o_rate = 18'h00708;
            5'h13: o_rate = 18'h007d0;
            5'h14: o_rate = 18'h00fa0;
            5'h15: o_rate = 18'h01f40;
            5'h16: o_rate = 18'h02ee0;
            5'h17: o_rate = 18'h03e80;
            5'h18: o_rate = 18'h04e20;
            5'h19: o_rate = 18'h09c40;
            5'h1a: o_rate = 18'h0ea60;
            5'h1b: o_rate = 18'h13880;
            5'h1c: o_rate = 18'h186a0;
            5'h1d: o_rate = 18'h1d4c0;
            5'h1e: o_rate = 18'h222e0;
            default: begin
                o_rate      = 18'h00000;
                o_unlimited = 1'b1;
            end
        endcase
    end

endmodule
